// ---- mcr_consts.svh ----
`ifndef MCR_CONSTS_SVH
`define MCR_CONSTS_SVH

// =============================================================
// Register indices (byte address = index * 4)
`define MCR_IDX_MEAS_MODE       16'he700
`define MCR_IDX_ACCUM_MODE      16'he701
`define MCR_IDX_LINE_CYC        16'he702
`define MCR_IDX_PEAK_WIN        16'he703
`define MCR_IDX_DIP_WIN         16'he704
`define MCR_IDX_PULSE_LATCH     16'he705
`define MCR_IDX_FAST_CAP        16'he706
`define MCR_IDX_DIE_REV         16'he707
`define MCR_IDX_REMOTE_CONV     16'he708
`define MCR_IDX_TEMP_A          16'he709
`define MCR_IDX_TEMP_B          16'he70a
`define MCR_IDX_TEMP_C          16'he70b
`define MCR_IDX_TEMP_N          16'he70c
`define MCR_IDX_PROT_KEY1       16'he7e3
`define MCR_IDX_LAST_BYTE       16'he7fd
`define MCR_IDX_PROT_KEY2       16'he7fe
`define MCR_IDX_PF_A            16'he902
`define MCR_IDX_PF_B            16'he903
`define MCR_IDX_PF_C            16'he904
`define MCR_IDX_PER_A           16'he905
`define MCR_IDX_PER_B           16'he906
`define MCR_IDX_PER_C           16'he907
`define MCR_IDX_AP_NOLOAD       16'he908
`define MCR_IDX_LAST_ADDR       16'he9fe

// =============================================================
// Reset values
`define MCR_RST_MEAS_MODE       8'h1c
`define MCR_RST_ACCUM_MODE      8'h80
`define MCR_RST_LINE_CYC        8'h78
`define MCR_RST_PEAK_WIN        8'h00
`define MCR_RST_DIP_WIN         8'h00
`define MCR_RST_PULSE_LATCH     8'h01
`define MCR_RST_FAST_CAP        8'h00
`define MCR_RST_REMOTE_CONV     8'h0f
`define MCR_RST_PROT_KEY        8'h00
`define MCR_RST_AP_NOLOAD       16'h0000
`define MCR_RST_LAST            16'h0000
`define MCR_RST_LAST_BYTE       8'h00

// =============================================================
// Bus geometry
`define MCR_ADDR_W              18
`define MCR_IDX_LSB             2

`endif

// ---- mcr_pkg.sv ----
package mcr_pkg;

    typedef struct packed {
        logic [7:0]  meas_mode;
        logic [7:0]  accum_mode;
        logic [7:0]  line_cyc;
        logic [7:0]  peak_win;
        logic [7:0]  dip_win;
        logic [7:0]  pulse_latch;
        logic [7:0]  fast_cap;
        logic [7:0]  remote_conv;
        logic [7:0]  prot_key1;
        logic [7:0]  prot_key2;
        logic [15:0] ap_noload;
    } mcr_cfg_s;

    typedef struct packed {
        logic [7:0]  temp_a;
        logic [7:0]  temp_b;
        logic [7:0]  temp_c;
        logic [7:0]  temp_n;
        logic [15:0] pf_a;
        logic [15:0] pf_b;
        logic [15:0] pf_c;
        logic [15:0] per_a;
        logic [15:0] per_b;
        logic [15:0] per_c;
    } mcr_meas_s;

    typedef enum logic [1:0] {
        MCR_SZ_NONE,
        MCR_SZ_8,
        MCR_SZ_16
    } mcr_size_e;

endpackage

// ---- mcr_regs.sv ----
`include "mcr_consts.svh"

module mcr_regs
    import mcr_pkg::*;
#(
    parameter logic [7:0] DIE_REVISION = 8'h01  // Arbitrary value
) (
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_sys_rst,
    input  wire logic [`MCR_ADDR_W-1:0] i_avs_address,
    input  wire logic                   i_avs_read,
    input  wire logic                   i_avs_write,
    input  wire logic [31:0]            i_avs_writedata,
    input  wire logic [3:0]             i_avs_byteenable,
    output logic      [31:0]            o_avs_readdata,
    output logic                        o_avs_waitrequest,
    input  wire mcr_meas_s              i_meas,
    output mcr_cfg_s                    o_cfg
);

    // =============================================================
    // Decode
    function automatic logic [15:0] idx_of(input logic [`MCR_ADDR_W-1:0] a);
        idx_of = a[`MCR_ADDR_W-1:`MCR_IDX_LSB];
    endfunction

    function automatic mcr_size_e size_of(input logic [15:0] idx);
        case (idx)
            `MCR_IDX_MEAS_MODE, `MCR_IDX_ACCUM_MODE, `MCR_IDX_LINE_CYC,
            `MCR_IDX_PEAK_WIN, `MCR_IDX_DIP_WIN, `MCR_IDX_PULSE_LATCH,
            `MCR_IDX_FAST_CAP, `MCR_IDX_DIE_REV, `MCR_IDX_REMOTE_CONV,
            `MCR_IDX_TEMP_A, `MCR_IDX_TEMP_B, `MCR_IDX_TEMP_C,
            `MCR_IDX_TEMP_N, `MCR_IDX_PROT_KEY1, `MCR_IDX_LAST_BYTE,
            `MCR_IDX_PROT_KEY2: size_of = MCR_SZ_8;
            `MCR_IDX_PF_A, `MCR_IDX_PF_B, `MCR_IDX_PF_C,
            `MCR_IDX_PER_A, `MCR_IDX_PER_B, `MCR_IDX_PER_C,
            `MCR_IDX_AP_NOLOAD, `MCR_IDX_LAST_ADDR: size_of = MCR_SZ_16;
            default: size_of = MCR_SZ_NONE;
        endcase
    endfunction

    mcr_cfg_s    cfg_r;
    logic [7:0]  last_byte_r;
    logic [15:0] last_addr_r;
    logic        wait_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [15:0] idx;
    mcr_size_e   size;
    logic        req;
    logic        done;
    logic        wr_done;

    assign idx     = idx_of(i_avs_address);
    assign size    = size_of(idx);
    assign req     = i_avs_read | i_avs_write;
    // Completion is the cycle the master sees waitrequest low
    assign done    = req & ~wait_r;
    assign wr_done = done & i_avs_write;

    // =============================================================
    // Read mux
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (idx)
            `MCR_IDX_MEAS_MODE:   rdata_nxt[7:0]  = cfg_r.meas_mode;
            `MCR_IDX_ACCUM_MODE:  rdata_nxt[7:0]  = cfg_r.accum_mode;
            `MCR_IDX_LINE_CYC:    rdata_nxt[7:0]  = cfg_r.line_cyc;
            `MCR_IDX_PEAK_WIN:    rdata_nxt[7:0]  = cfg_r.peak_win;
            `MCR_IDX_DIP_WIN:     rdata_nxt[7:0]  = cfg_r.dip_win;
            `MCR_IDX_PULSE_LATCH: rdata_nxt[7:0]  = cfg_r.pulse_latch;
            `MCR_IDX_FAST_CAP:    rdata_nxt[7:0]  = cfg_r.fast_cap;
            `MCR_IDX_DIE_REV:     rdata_nxt[7:0]  = DIE_REVISION;
            `MCR_IDX_REMOTE_CONV: rdata_nxt[7:0]  = cfg_r.remote_conv;
            `MCR_IDX_TEMP_A:      rdata_nxt[7:0]  = i_meas.temp_a;
            `MCR_IDX_TEMP_B:      rdata_nxt[7:0]  = i_meas.temp_b;
            `MCR_IDX_TEMP_C:      rdata_nxt[7:0]  = i_meas.temp_c;
            `MCR_IDX_TEMP_N:      rdata_nxt[7:0]  = i_meas.temp_n;
            `MCR_IDX_PROT_KEY1:   rdata_nxt[7:0]  = cfg_r.prot_key1;
            `MCR_IDX_LAST_BYTE:   rdata_nxt[7:0]  = last_byte_r;
            `MCR_IDX_PROT_KEY2:   rdata_nxt[7:0]  = cfg_r.prot_key2;
            `MCR_IDX_PF_A:        rdata_nxt[15:0] = i_meas.pf_a;
            `MCR_IDX_PF_B:        rdata_nxt[15:0] = i_meas.pf_b;
            `MCR_IDX_PF_C:        rdata_nxt[15:0] = i_meas.pf_c;
            `MCR_IDX_PER_A:       rdata_nxt[15:0] = i_meas.per_a;
            `MCR_IDX_PER_B:       rdata_nxt[15:0] = i_meas.per_b;
            `MCR_IDX_PER_C:       rdata_nxt[15:0] = i_meas.per_c;
            `MCR_IDX_AP_NOLOAD:   rdata_nxt[15:0] = cfg_r.ap_noload;
            `MCR_IDX_LAST_ADDR:   rdata_nxt[15:0] = last_addr_r;
            default:              rdata_nxt       = 32'h0000_0000;
        endcase
    end

    // =============================================================
    // Bus handshake: one wait cycle, then completion
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            wait_r <= 1'b1;
        end else if (done) begin
            wait_r <= 1'b1;
        end else if (req) begin
            wait_r <= 1'b0;
        end
    end

    // Sampled in the wait cycle so data stands when waitrequest drops
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (req & wait_r & i_avs_read) begin
            rdata_r <= rdata_nxt;
        end
    end

    // =============================================================
    // Writable registers; read-only and reserved indices fall to default
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            cfg_r.meas_mode   <= `MCR_RST_MEAS_MODE;
            cfg_r.accum_mode  <= `MCR_RST_ACCUM_MODE;
            cfg_r.line_cyc    <= `MCR_RST_LINE_CYC;
            cfg_r.peak_win    <= `MCR_RST_PEAK_WIN;
            cfg_r.dip_win     <= `MCR_RST_DIP_WIN;
            cfg_r.pulse_latch <= `MCR_RST_PULSE_LATCH;
            cfg_r.fast_cap    <= `MCR_RST_FAST_CAP;
            cfg_r.remote_conv <= `MCR_RST_REMOTE_CONV;
            cfg_r.prot_key1   <= `MCR_RST_PROT_KEY;
            cfg_r.prot_key2   <= `MCR_RST_PROT_KEY;
            cfg_r.ap_noload   <= `MCR_RST_AP_NOLOAD;
        end else if (wr_done) begin
            if (i_avs_byteenable[0]) begin
                case (idx)
                    `MCR_IDX_MEAS_MODE:   cfg_r.meas_mode   <= i_avs_writedata[7:0];
                    `MCR_IDX_ACCUM_MODE:  cfg_r.accum_mode  <= i_avs_writedata[7:0];
                    `MCR_IDX_LINE_CYC:    cfg_r.line_cyc    <= i_avs_writedata[7:0];
                    `MCR_IDX_PEAK_WIN:    cfg_r.peak_win    <= i_avs_writedata[7:0];
                    `MCR_IDX_DIP_WIN:     cfg_r.dip_win     <= i_avs_writedata[7:0];
                    `MCR_IDX_PULSE_LATCH: cfg_r.pulse_latch <= i_avs_writedata[7:0];
                    `MCR_IDX_FAST_CAP:    cfg_r.fast_cap    <= i_avs_writedata[7:0];
                    `MCR_IDX_REMOTE_CONV: cfg_r.remote_conv <= i_avs_writedata[7:0];
                    `MCR_IDX_PROT_KEY1:   cfg_r.prot_key1   <= i_avs_writedata[7:0];
                    `MCR_IDX_PROT_KEY2:   cfg_r.prot_key2   <= i_avs_writedata[7:0];
                    `MCR_IDX_AP_NOLOAD:   cfg_r.ap_noload[7:0] <= i_avs_writedata[7:0];
                    default: ;
                endcase
            end
            if (i_avs_byteenable[1] && idx == `MCR_IDX_AP_NOLOAD) begin
                cfg_r.ap_noload[15:8] <= i_avs_writedata[15:8];
            end
        end
    end

    // =============================================================
    // Last-transfer capture; unmapped accesses do not count as successful
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            last_byte_r <= `MCR_RST_LAST_BYTE;
        end else if (done && size == MCR_SZ_8) begin
            last_byte_r <= i_avs_write ? i_avs_writedata[7:0] : rdata_r[7:0];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            last_addr_r <= `MCR_RST_LAST;
        end else if (done && size != MCR_SZ_NONE) begin
            last_addr_r <= idx;
        end
    end

    assign o_avs_readdata    = rdata_r;
    assign o_avs_waitrequest = wait_r;
    assign o_cfg             = cfg_r;

endmodule

// ---- mcr_regs_sva.sv ----
`include "mcr_consts.svh"
module mcr_regs_sva
    import mcr_pkg::*;
(
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_sys_rst,
    input  wire logic [`MCR_ADDR_W-1:0] i_avs_address,
    input  wire logic                   i_avs_read,
    input  wire logic                   i_avs_write,
    input  wire logic [31:0]            i_avs_writedata,
    input  wire logic [3:0]             i_avs_byteenable,
    input  wire logic [31:0]            o_avs_readdata,
    input  wire logic                   o_avs_waitrequest,
    input  wire mcr_meas_s              i_meas,
    input  wire mcr_cfg_s               o_cfg
);
    // =========================================
    // Completion qualifiers
    wire logic        rd_done = i_avs_read && !o_avs_waitrequest;
    wire logic        wr_done = i_avs_write && !o_avs_waitrequest;
    wire logic [15:0] idx     = i_avs_address[17:2];

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    // =========================================
    // Properties
    property p_rst_cfg;
        $fell(i_sys_rst) |-> o_cfg == {`MCR_RST_MEAS_MODE, `MCR_RST_ACCUM_MODE, `MCR_RST_LINE_CYC, `MCR_RST_PEAK_WIN,
            `MCR_RST_DIP_WIN, `MCR_RST_PULSE_LATCH, `MCR_RST_FAST_CAP, `MCR_RST_REMOTE_CONV, `MCR_RST_PROT_KEY,
            `MCR_RST_PROT_KEY, `MCR_RST_AP_NOLOAD};
    endproperty
    a_rst_cfg: assert property (p_rst_cfg) else $error("config not at reset values");
    property p_answer;
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered in one cycle");
    property p_no_spurious;
        !o_avs_waitrequest |-> $past(i_avs_read || i_avs_write);
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("answer without request");
    property p_wr8;
        wr_done && idx == `MCR_IDX_PULSE_LATCH && i_avs_byteenable[0] |=> o_cfg.pulse_latch == $past(i_avs_writedata[7:0]);
    endproperty
    a_wr8: assert property (p_wr8) else $error("pulse latch count not written");
    property p_wr16;
        wr_done && idx == `MCR_IDX_AP_NOLOAD && i_avs_byteenable[1:0] == 2'b11
            |=> o_cfg.ap_noload == $past(i_avs_writedata[15:0]);
    endproperty
    a_wr16: assert property (p_wr16) else $error("no-load threshold not written");
    // Writes to read-only or reserved indices must leave every config field alone
    property p_hold;
        !(wr_done && (idx inside {`MCR_IDX_MEAS_MODE, `MCR_IDX_ACCUM_MODE, `MCR_IDX_LINE_CYC, `MCR_IDX_PEAK_WIN,
            `MCR_IDX_DIP_WIN, `MCR_IDX_PULSE_LATCH, `MCR_IDX_FAST_CAP, `MCR_IDX_REMOTE_CONV, `MCR_IDX_PROT_KEY1,
            `MCR_IDX_PROT_KEY2, `MCR_IDX_AP_NOLOAD})) |=> $stable(o_cfg);
    endproperty
    a_hold: assert property (p_hold) else $error("config changed without a write");
    property p_temp;
        rd_done && idx == `MCR_IDX_TEMP_A |-> o_avs_readdata == {24'h0, $past(i_meas.temp_a)};
    endproperty
    a_temp: assert property (p_temp) else $error("temperature offset read wrong");
    property p_pf;
        rd_done && idx == `MCR_IDX_PF_A |-> o_avs_readdata == {16'h0, $past(i_meas.pf_a)};
    endproperty
    a_pf: assert property (p_pf) else $error("power factor read wrong");
    property p_per;
        rd_done && idx == `MCR_IDX_PER_C |-> o_avs_readdata == {16'h0, $past(i_meas.per_c)};
    endproperty
    a_per: assert property (p_per) else $error("line period read wrong");
endmodule

bind mcr_regs mcr_regs_sva chk_u (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_meas(i_meas), .o_cfg(o_cfg)
);

// ---- tb_metering_config_regs.sv ----
`include "mcr_consts.svh"
module tb_metering_config_regs
    import mcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] REV = 8'h5a;  // Arbitrary value
    logic        clk, rst, rd, wr, wq;
    logic [17:0] addr;
    logic [31:0] wd, rdata, q, d;
    logic [3:0]  be;
    mcr_meas_s   meas;
    mcr_cfg_s    cfg;
    int          errors, n_tests;
    logic [15:0] rw_idx[11] = '{16'he700, 16'he701, 16'he702, 16'he703, 16'he704, 16'he705, 16'he706, 16'he708,
                                16'he7e3, 16'he7fe, 16'he908};
    logic [15:0] rw_rst[11] = '{16'h1c, 16'h80, 16'h78, 16'h0, 16'h0, 16'h1, 16'h0, 16'h0f, 16'h0, 16'h0, 16'h0};
    logic [15:0] ro_idx[11] = '{16'he707, 16'he709, 16'he70a, 16'he70b, 16'he70c, 16'he902, 16'he903, 16'he904,
                                16'he905, 16'he906, 16'he907};
    logic [15:0] rsv_idx[6] = '{16'he70d, 16'he7e2, 16'he7e4, 16'he7fc, 16'he7ff, 16'he901};
    logic [31:0] exp_v[11];

    mcr_regs #(.DIE_REVISION(REV)) dut_u (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wq),
        .i_meas(meas), .o_cfg(cfg)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // =========================================
    // Expectations and bus access
    function automatic logic [31:0] ro_exp(input logic [15:0] i, input mcr_meas_s m);
        case (i)
            16'he707: return {24'h0, REV};
            16'he709: return {24'h0, m.temp_a};
            16'he70a: return {24'h0, m.temp_b};
            16'he70b: return {24'h0, m.temp_c};
            16'he70c: return {24'h0, m.temp_n};
            16'he902: return {16'h0, m.pf_a};
            16'he903: return {16'h0, m.pf_b};
            16'he904: return {16'h0, m.pf_c};
            16'he905: return {16'h0, m.per_a};
            16'he906: return {16'h0, m.per_b};
            default: return {16'h0, m.per_c};
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request left raised so that calls run back to back
    task automatic bus(input logic w, input logic [15:0] i, input logic [31:0] dd, input logic [3:0] b);
        int n;
        n = 0;
        wr <= w;
        rd <= !w;
        addr <= {i, 2'b00};
        wd <= dd;
        be <= b;
        @(posedge clk);
        while (wq !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) begin
            errors++;
            results();
        end
        q = rdata;
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        errors++;
        results();
    end

    // =========================================
    // Main sequence
    initial begin
        rst = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        addr = '0;
        wd = '0;
        be = '0;
        meas = '0;
        errors = 0;
        n_tests = 0;
        void'($urandom(61));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            bus(1'b0, rw_idx[i], 32'h0, 4'hf);
            chk(q, {16'h0, rw_rst[i]});
        end
        $display("test reset values done");
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 11; i++) begin
                d = $urandom;
                bus(1'b1, rw_idx[i], d, 4'hf);
                exp_v[i] = d & (i == 10 ? 32'hffff : 32'hff);
            end
            bus(1'b0, `MCR_IDX_LAST_BYTE, 32'h0, 4'hf);
            chk(q, exp_v[9]);
            bus(1'b0, `MCR_IDX_LAST_ADDR, 32'h0, 4'hf);
            chk(q, {16'h0, `MCR_IDX_LAST_BYTE});
            // Lane 0 off: must not land
            bus(1'b1, `MCR_IDX_MEAS_MODE, ~exp_v[0], 4'h0);
            // Upper lane only: low byte of the threshold must survive
            d = $urandom;
            bus(1'b1, `MCR_IDX_AP_NOLOAD, d, 4'h2);
            exp_v[10] = {16'h0, d[15:8], exp_v[10][7:0]};
            for (int i = 0; i < 11; i++) begin
                bus(1'b0, rw_idx[i], 32'h0, 4'hf);
                chk(q, exp_v[i]);
            end
            chk({24'h0, cfg.meas_mode}, exp_v[0]);
            meas <= {$urandom, $urandom, $urandom, $urandom};
            for (int i = 0; i < 11; i++) begin
                bus(1'b1, ro_idx[i], $urandom, 4'hf);
                bus(1'b0, ro_idx[i], 32'h0, 4'hf);
                chk(q, ro_exp(ro_idx[i], meas));
            end
            // Reserved space is only ever read
            for (int i = 0; i < 6; i++) begin
                bus(1'b0, rsv_idx[i], 32'h0, 4'hf);
                chk(q, 32'h0);
            end
            rd <= 1'b0;
            wr <= 1'b0;
            @(posedge clk);
            $display("test round %0d done", r);
        end
        // Mid-run reset must bring every writable register back
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            bus(1'b0, rw_idx[i], 32'h0, 4'hf);
            chk(q, {16'h0, rw_rst[i]});
        end
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
        $display("test mid-run reset done");
        results();
    end
endmodule
